//--- src/adc_ctl_pkg.sv
// package for the dual slope converter control block
// assumes an ahb-lite slave with 32-bit data and one clock
package adc_ctl_pkg;
  localparam logic [7:0] CTRL_OFS = 8'h18;
  localparam logic [7:0] DIV_OFS = 8'h1A;
  // register indices; the byte address is four times the index
  localparam logic [7:0] CTRL_ADDR = {CTRL_OFS[5:0], 2'b00};
  localparam logic [7:0] DIV_ADDR = {DIV_OFS[5:0], 2'b00};
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h20;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h24;
  localparam logic [7:0] AUX_OFS = 8'h28;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h77;
  localparam logic [7:0] DIV_WMASK = 8'h9F;
  localparam int POWER_BIT = 0;
  localparam int PHASE_LSB = 1;
  localparam int CMP_BIT = 3;
  localparam int MODE_LSB = 4;
  localparam int CHOP_EN_BIT = 6;
  localparam int DIVN_LSB = 0;
  localparam int INSEL_BIT = 3;
  localparam int REFSEL_BIT = 4;
  localparam int GAIN_BIT = 7;
  localparam int PRESCALE = 32;
  localparam logic [1:0] PHASE_CHARGE = 2'b01;
  localparam logic [1:0] PHASE_DISCHARGE = 2'b10;
  localparam logic [1:0] MODE_RISE = 2'b01;
  localparam logic [1:0] MODE_FALL = 2'b10;
  localparam logic [1:0] MODE_BOTH = 2'b11;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  typedef struct packed {
    logic analog_power_on;
    logic integrate_from_buffer;
    logic integrate_from_reference;
    logic chopper_clock;
    logic amp_input_select;
    logic reference_ratio_select;
    logic amp_gain_select;
  } analog_ctl_t;
endpackage

//--- src/dual_slope_adc_control.sv
// dual slope converter control: two 8-bit registers plus interrupt registers on ahb-lite
// assumes the analog integrator and comparator sit outside and comparator_in is synchronous
// Overview of operation
// - comparator output falls when capacitor node drops below one sixth reference
// - control bit 0 powers converter and amplifier when set
// - phase field 01 integrates buffer, 10 integrates reference, others reserved
// - control bit 3 reads comparator, read only, writes ignored
// - during discharge the comparator status bit falls below comparator reference
// - mode field: 00 none, 01 rising, 10 falling, 11 both edges
// - control bit 6 gates chopper clock at divider rate
// - unimplemented bits read zero: control bit 7, divider bits 5 and 6
// - chopper clock is system clock over 32 then over two to n
// - divider bit 3 selects alternate sensor input instead of chopper input
// - divider bit 4 selects 4.4/6 instead of 4/6 integrator reference
// - divider bit 7 selects amplifier gain four instead of two
// - regulator off disables converter and amplifier regardless of power bit
`default_nettype none
module dual_slope_adc_control #(
  parameter int DIVN_WIDTH = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic comparator_in,
  input wire logic regulator_module_on,
  output adc_ctl_pkg::analog_ctl_t analog_ctl,
  output logic irq
);
  import adc_ctl_pkg::*;

  localparam int DIV_MAX_BITS = $clog2(PRESCALE) + (1 << DIVN_WIDTH) - 1;

  logic [7:0] converter_control;
  logic [7:0] chopper_divider_and_input_select;
  logic irq_status;
  logic irq_mask;
  logic comparator_out;
  logic cmp_prev;
  logic [DIV_MAX_BITS-1:0] chop_count;
  logic chopper_clock;
  logic wr_pend;
  logic [7:0] wr_addr;

  // address phase capture
  wire addr_valid = hsel & hready & (htrans == HTRANS_NONSEQ);
  wire rd_now = addr_valid & ~hwrite;
  wire [7:0] word_addr = {haddr[7:2], 2'b00};
  wire wr_ctrl = wr_pend & (wr_addr == CTRL_ADDR);
  wire wr_div = wr_pend & (wr_addr == DIV_ADDR);
  wire wr_status = wr_pend & (wr_addr == IRQ_STATUS_OFS);
  wire wr_mask = wr_pend & (wr_addr == IRQ_MASK_OFS);

  // control fields
  wire power_bit = converter_control[POWER_BIT];
  wire [1:0] phase = converter_control[PHASE_LSB +: 2];
  wire [1:0] irq_mode = converter_control[MODE_LSB +: 2];
  wire chop_en = converter_control[CHOP_EN_BIT];
  wire [DIVN_WIDTH-1:0] divn = chopper_divider_and_input_select[DIVN_LSB +: DIVN_WIDTH];
  wire converter_on = power_bit & regulator_module_on;

  // edge detection on comparator status
  wire rise = comparator_out & ~cmp_prev;
  wire fall = ~comparator_out & cmp_prev;
  wire edge_hit = converter_on & (((irq_mode == MODE_RISE) & rise) |
    ((irq_mode == MODE_FALL) & fall) | ((irq_mode == MODE_BOTH) & (rise | fall)));

  // chopper divider: toggle every 16 << n cycles gives clk/32/2^n
  wire [DIV_MAX_BITS-1:0] half_period =
    DIV_MAX_BITS'((PRESCALE / 2) << divn);
  wire chop_tick = (chop_count == half_period - DIV_MAX_BITS'(1));

  // read mux: unmapped addresses and reserved bits read zero
  wire [7:0] ctrl_view = {1'b0, converter_control[6:4], comparator_out,
    converter_control[2:0]};
  wire [7:0] div_view = chopper_divider_and_input_select & DIV_WMASK;
  wire [31:0] next_hrdata =
    (word_addr == CTRL_ADDR) ? {24'h000000, ctrl_view} :
    (word_addr == DIV_ADDR) ? {24'h000000, div_view} :
    (word_addr == IRQ_STATUS_OFS) ? {31'h00000000, irq_status} :
    (word_addr == IRQ_MASK_OFS) ? {31'h00000000, irq_mask} :
    (word_addr == AUX_OFS) ? {31'h00000000, regulator_module_on} : 32'h00000000;

  // analog outputs
  analog_ctl_t next_analog_ctl;
  always_comb begin
    next_analog_ctl.analog_power_on = converter_on;
    next_analog_ctl.integrate_from_buffer = converter_on & (phase == PHASE_CHARGE);
    next_analog_ctl.integrate_from_reference = converter_on & (phase == PHASE_DISCHARGE);
    next_analog_ctl.chopper_clock = chopper_clock;
    next_analog_ctl.amp_input_select = chopper_divider_and_input_select[INSEL_BIT];
    next_analog_ctl.reference_ratio_select = chopper_divider_and_input_select[REFSEL_BIT];
    next_analog_ctl.amp_gain_select = chopper_divider_and_input_select[GAIN_BIT];
  end

  // bus data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend <= addr_valid & hwrite;
      wr_addr <= word_addr;
      if (rd_now) begin
        hrdata <= next_hrdata;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // register writes; reserved and read-only bits masked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      converter_control <= CTRL_RESET;
      chopper_divider_and_input_select <= DIV_RESET;
      irq_mask <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        converter_control <= hwdata[7:0] & CTRL_WMASK;
      end
      if (wr_div) begin
        chopper_divider_and_input_select <= hwdata[7:0] & DIV_WMASK;
      end
      if (wr_mask) begin
        irq_mask <= hwdata[0];
      end
    end
  end

  // comparator status follows the analog comparator; falls at one sixth reference
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      comparator_out <= 1'b0;
      cmp_prev <= 1'b0;
    end else begin
      comparator_out <= converter_on & comparator_in;
      cmp_prev <= comparator_out;
    end
  end

  // sticky edge flag, set beats write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status <= 1'b0;
    end else if (edge_hit) begin
      irq_status <= 1'b1;
    end else if (wr_status & hwdata[0]) begin
      irq_status <= 1'b0;
    end
  end

  // chopper clock divider, stopped when gated off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chop_count <= '0;
      chopper_clock <= 1'b0;
    end else if (!(chop_en & converter_on)) begin
      chop_count <= '0;
      chopper_clock <= 1'b0;
    end else if (wr_div) begin
      chop_count <= '0;
    end else if (chop_tick) begin
      chop_count <= '0;
      chopper_clock <= ~chopper_clock;
    end else begin
      chop_count <= chop_count + DIV_MAX_BITS'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog_ctl <= '0;
      irq <= 1'b0;
    end else begin
      analog_ctl <= next_analog_ctl;
      irq <= irq_status & irq_mask;
    end
  end

  // assertions
  sequence rise_seen_s;
    converter_on && irq_mode == MODE_RISE && rise;
  endsequence
  sequence fall_seen_s;
    converter_on && irq_mode == MODE_FALL && fall;
  endsequence
  sequence both_seen_s;
    converter_on && irq_mode == MODE_BOTH && (rise || fall);
  endsequence
  sequence flag_up_s;
    ##1 irq_status;
  endsequence
  sequence ctrl_write_s;
    addr_valid && hwrite && word_addr == CTRL_ADDR;
  endsequence
  sequence div_write_s;
    addr_valid && hwrite && word_addr == DIV_ADDR;
  endsequence

  // power and phase
  power_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !regulator_module_on |=> !analog_ctl.analog_power_on)
    else $error("converter powered while regulator off");

  power_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (power_bit && regulator_module_on) |=> analog_ctl.analog_power_on)
    else $error("converter not powered");

  unpowered_cmp_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !converter_on |=> !comparator_out)
    else $error("comparator status live while unpowered");

  cmp_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
    converter_on |=> comparator_out == $past(comparator_in))
    else $error("comparator status lost");

  phase_map_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (converter_on && phase != PHASE_CHARGE) |=> !analog_ctl.integrate_from_buffer)
    else $error("charge phase driven for wrong code");

  ref_phase_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (converter_on && phase != PHASE_DISCHARGE) |=> !analog_ctl.integrate_from_reference)
    else $error("discharge phase driven for wrong code");

  charge_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (converter_on && phase == PHASE_CHARGE) |=> analog_ctl.integrate_from_buffer)
    else $error("charge phase not driven");

  discharge_on_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (converter_on && phase == PHASE_DISCHARGE) |=> analog_ctl.integrate_from_reference)
    else $error("discharge phase not driven");

  phase_excl_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !(analog_ctl.integrate_from_buffer && analog_ctl.integrate_from_reference))
    else $error("both integrator inputs driven");

  // register bus
  cmp_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_now && word_addr == CTRL_ADDR |=> hrdata[CMP_BIT] == $past(comparator_out))
    else $error("comparator bit read wrong");

  ctrl_read_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_now && word_addr == CTRL_ADDR) |=> hrdata[31:7] == 25'h0000000)
    else $error("control reserved bits read nonzero");

  div_read_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_now && word_addr == DIV_ADDR) |=>
      (hrdata[6:5] == 2'b00 && hrdata[31:8] == 24'h000000))
    else $error("divider reserved bits read nonzero");

  ctrl_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl_write_s |=> ##1 converter_control == ($past(hwdata[7:0]) & CTRL_WMASK))
    else $error("control write lost");

  div_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    div_write_s |=> ##1
      chopper_divider_and_input_select == ($past(hwdata[7:0]) & DIV_WMASK))
    else $error("divider write lost");

  reserved_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
    converter_control[7] == 1'b0 && chopper_divider_and_input_select[6:5] == 2'b00)
    else $error("reserved bit set");

  // interrupt flag
  rise_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rise_seen_s |-> flag_up_s)
    else $error("rising edge lost");

  fall_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
    fall_seen_s |-> flag_up_s)
    else $error("falling edge lost");

  both_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
    both_seen_s |-> flag_up_s)
    else $error("edge lost in both edge mode");

  edge_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    edge_hit |=> irq_status)
    else $error("enabled edge did not set the flag");

  flag_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (irq_status && !(wr_status && hwdata[0])) |=> irq_status)
    else $error("pending flag dropped");

  flag_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_status && hwdata[0] && !edge_hit) |=> !irq_status)
    else $error("flag not cleared");

  no_irq_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (irq_mode == 2'b00 && !irq_status) |=> !irq_status)
    else $error("flag set with interrupts off");

  irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> irq == ($past(irq_status) && $past(irq_mask)))
    else $error("interrupt line wrong");

  // chopper and amplifier
  chop_stop_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !chop_en [*2] |=> !analog_ctl.chopper_clock)
    else $error("chopper clock runs while gated");

  gate_power_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !converter_on [*2] |=> !analog_ctl.chopper_clock)
    else $error("chopper clock runs while unpowered");

  chop_period_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (chop_en && converter_on && chop_count > half_period) |-> 1'b0)
    else $error("divider count past half period");

  chop_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (chop_en && converter_on && !wr_div && chop_tick) |=>
      chopper_clock != $past(chopper_clock))
    else $error("chopper clock missed a toggle");

  chop_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (chop_en && converter_on && !chop_tick) |=> chopper_clock == $past(chopper_clock))
    else $error("chopper clock toggled early");

  gain_map_a: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> analog_ctl.amp_gain_select == $past(chopper_divider_and_input_select[GAIN_BIT]))
    else $error("gain select wrong");

  insel_map_a: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> analog_ctl.amp_input_select ==
      $past(chopper_divider_and_input_select[INSEL_BIT]))
    else $error("input select wrong");

  refsel_map_a: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> analog_ctl.reference_ratio_select ==
      $past(chopper_divider_and_input_select[REFSEL_BIT]))
    else $error("reference select wrong");
endmodule // dual_slope_adc_control
`default_nettype wire

//--- test/comparator_model.sv
// behavioural integrator and comparator facing the converter control block
// assumes analog_ctl comes from the design and hclk is the system clock
`default_nettype none
module comparator_model #(
  parameter int FULL = 32,
  parameter int THRESH = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire adc_ctl_pkg::analog_ctl_t analog_ctl,
  output logic comparator_in
);
  timeunit 1ns;
  timeprecision 1ns;
  import adc_ctl_pkg::*;
  int level;
  // charge ramps the capacitor up, discharge ramps it down
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      level <= 0;
    else if (analog_ctl.integrate_from_buffer && level < FULL)
      level <= level + 1;
    else if (analog_ctl.integrate_from_reference && level > 0)
      level <= level - 1;
  end
  // low at or below THRESH, one quarter of FULL, and low while unpowered
  assign comparator_in = analog_ctl.analog_power_on && (level > THRESH);
endmodule // comparator_model
`default_nettype wire

//--- test/dual_slope_adc_control_test.sv
// self-checking testbench for the dual slope converter control block
// assumes the design package, the design and the comparator model are compiled first
`default_nettype none
module dual_slope_adc_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  import adc_ctl_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic regulator_module_on = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'h2;
  wire logic [31:0] hrdata;
  wire logic hreadyout;
  wire logic hresp;
  wire logic irq;
  wire logic comparator_in;
  wire analog_ctl_t actl;
  int error_cnt = 0;
  int n_compared = 0;
  logic [31:0] rd;
  always #5 hclk = ~hclk;
  dual_slope_adc_control dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .comparator_in(comparator_in),
    .regulator_module_on(regulator_module_on), .analog_ctl(actl), .irq(irq));
  comparator_model far (.hclk(hclk), .hresetn(hresetn), .analog_ctl(actl),
    .comparator_in(comparator_in));
  task summarize;
    if (error_cnt == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task wait_edge(input logic ready_wait, output int k);
    logic c;
    c = actl.chopper_clock;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while ((ready_wait ? hreadyout !== 1'b1 : actl.chopper_clock === c) && k < 5000);
    if (k >= 5000) begin
      chk(32'h0, 32'h1);
      summarize();
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wait_edge(1'b1, k);
    htrans <= 2'b00;
    hwdata <= wd;
    wait_edge(1'b1, k);
    rd = hrdata;
  endtask
  function automatic logic [6:0] exp_ctl(input logic [7:0] v, input logic [7:0] d,
    input logic r);
    logic p;
    p = v[0] & r;
    return {p, p & (v[2:1] == PHASE_CHARGE), p & (v[2:1] == PHASE_DISCHARGE), 1'b0,
      d[3], d[4], d[7]};
  endfunction
  initial begin
    logic [7:0] v;
    logic [7:0] d;
    logic [7:0] md;
    logic r;
    int k;
    void'($urandom(32'hBC67));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h0);
    xfer(1'b0, DIV_ADDR, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 24; i++) begin
      v = 8'($urandom);
      d = (i == 0) ? 8'hFF : 8'($urandom);
      r = 1'($urandom);
      regulator_module_on <= r;
      xfer(1'b1, CTRL_ADDR, {24'h0, v});
      xfer(1'b1, DIV_ADDR, {24'h0, d});
      xfer(1'b0, CTRL_ADDR, 32'h0);
      chk(rd & 32'hFFFFFFF7, {24'h0, v & 8'h77});
      xfer(1'b0, DIV_ADDR, 32'h0);
      chk(rd, {24'h0, d & 8'h9F});
      chk({25'h0, actl & 7'h77}, {25'h0, exp_ctl(v, d, r) & 7'h77});
      xfer(1'b0, AUX_OFS, 32'h0);
      chk(rd, {31'h0, r});
      xfer(1'b0, 8'h30, 32'h0);
      chk(rd, 32'h0);
    end
    regulator_module_on <= 1'b1;
    xfer(1'b1, IRQ_MASK_OFS, 32'h1);
    for (int mi = 0; mi < 4; mi++) begin
      md = {2'b00, 2'(mi), 4'h0};
      xfer(1'b1, CTRL_ADDR, {24'h0, md | 8'h05});
      repeat (40) @(posedge hclk);
      xfer(1'b1, IRQ_STATUS_OFS, 32'h1);
      xfer(1'b1, CTRL_ADDR, {24'h0, md | 8'h03});
      repeat (40) @(posedge hclk);
      xfer(1'b0, CTRL_ADDR, 32'h0);
      chk(rd, {24'h0, md | 8'h0B});
      xfer(1'b0, IRQ_STATUS_OFS, 32'h0);
      chk(rd, 32'(mi & 1));
      chk({31'h0, irq}, 32'(mi & 1));
      xfer(1'b1, IRQ_STATUS_OFS, 32'h1);
      xfer(1'b1, CTRL_ADDR, {24'h0, md | 8'h05});
      repeat (40) @(posedge hclk);
      xfer(1'b0, CTRL_ADDR, 32'h0);
      chk(rd, {24'h0, md | 8'h05});
      xfer(1'b0, IRQ_STATUS_OFS, 32'h0);
      chk(rd, 32'(mi >> 1));
    end
    xfer(1'b1, IRQ_MASK_OFS, 32'h0);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, CTRL_ADDR, 32'h41);
    for (int n = 0; n < 8; n++) begin
      xfer(1'b1, DIV_ADDR, 32'(n));
      repeat (3) wait_edge(1'b0, k);
      chk(32'(k), 32'((PRESCALE / 2) << n));
    end
    summarize();
  end
endmodule // dual_slope_adc_control_test
`default_nettype wire
